// ===== design/ubt_top.sv
// uart baud generator, frame format and transmit path
`timescale 1ns/1ps
`default_nettype none
`include "ubt_cfg.svh"

module ubt_top
  import ubt_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // serial pins
  output logic             tx_o,
  output logic             tx_oe_n_o,
  output logic             rx_sel_o
);

  // ***************************************
  // helpers
  // ***************************************

  // word as it goes on the line, parity in the top slot
  function automatic logic [8:0] ubt_word(
    input logic [7:0] d,
    input logic       nb9,
    input logic       ninth,
    input logic       pen,
    input logic       odd
  );
    logic [8:0] w;
    w = {ninth, d};
    if (pen)
    begin
      if (nb9)
        w[8] = (^d) ^ odd;
      else
        w[7] = (^d[6:0]) ^ odd;
    end
    // without parity the top bit passes as sent
    return w;
  endfunction

  // ***************************************
  // state and decode
  // ***************************************

  ubt_state_t q;
  ubt_state_t n;

  logic       tick;
  logic       bit_en;
  logic       active;
  logic [5:0] pre_max;
  logic [3:0] last;
  logic       req;
  logic       take;
  logic       wr;
  logic [5:0] ofs;
  logic [31:0] rdata;

  // baud chain taps
  assign tick    = q.uart_en & (q.tmr == 8'h00);
  assign pre_max = q.hs ? `UBT_PRE_HIGH : `UBT_PRE_LOW;
  assign bit_en  = tick & (q.pre == pre_max);
  assign active  = q.uart_en & q.tx_en;
  assign last    = q.word9 ? `UBT_LAST9 : `UBT_LAST8;
  // bus handshake: effects land on the edge ack is seen
  assign req  = wb_cyc_i & wb_stb_i;
  assign take = req & q.ack;
  assign wr   = take & wb_we_i & wb_sel_i[0];
  assign ofs  = wb_adr_i[7:2];

  // read mux, unmapped reads return zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (ofs)
      `UBT_OFS_CTRL_FIRST:
      begin
        rdata[`UBT_B_UART_EN] = q.uart_en;
        rdata[`UBT_B_WORD9]   = q.word9;
        rdata[`UBT_B_PAR_EN]  = q.par_en;
        rdata[`UBT_B_PAR_ODD] = q.par_odd;
        rdata[`UBT_B_STOP2]   = q.stop2;
        rdata[`UBT_B_BRK]     = q.brk;
        rdata[`UBT_B_NINTH]   = q.ninth;
      end
      `UBT_OFS_CTRL_SECOND:
      begin
        rdata[`UBT_B_TX_EN] = q.tx_en;
        rdata[`UBT_B_RX_EN] = q.rx_en;
        rdata[`UBT_B_HS]    = q.hs;
      end
      `UBT_OFS_BAUD:
        rdata[7:0] = q.div;
      `UBT_OFS_STATUS:
      begin
        rdata[`UBT_B_TX_EMPTY] = ~q.hold_full;
        rdata[`UBT_B_TX_IDLE]  = q.idle_flag;
        // no receiver here, so it always reads idle
        rdata[`UBT_B_RX_IDLE]  = 1'b1;
      end
      `UBT_OFS_TXDATA:
        rdata[7:0] = q.hold;
      default:
        rdata = 32'h0000_0000;
    endcase
  end

  // ***************************************
  // next state
  // ***************************************

  always_comb
  begin
    n = q;
    // registered ack, one wait state
    n.ack = req & ~q.ack;
    if (req & ~q.ack)
      n.dat = rdata;

    // register writes
    if (wr)
    begin
      case (ofs)
        `UBT_OFS_CTRL_FIRST:
        begin
          n.uart_en = wb_dat_i[`UBT_B_UART_EN];
          n.word9   = wb_dat_i[`UBT_B_WORD9];
          n.par_en  = wb_dat_i[`UBT_B_PAR_EN];
          n.par_odd = wb_dat_i[`UBT_B_PAR_ODD];
          n.stop2   = wb_dat_i[`UBT_B_STOP2];
          n.brk     = wb_dat_i[`UBT_B_BRK];
          n.ninth   = wb_dat_i[`UBT_B_NINTH];
        end
        `UBT_OFS_CTRL_SECOND:
        begin
          n.tx_en = wb_dat_i[`UBT_B_TX_EN];
          n.rx_en = wb_dat_i[`UBT_B_RX_EN];
          n.hs    = wb_dat_i[`UBT_B_HS];
        end
        `UBT_OFS_BAUD:
          n.div = wb_dat_i[7:0];
        `UBT_OFS_TXDATA:
        begin
          // a full holding register refuses the word
          if (~q.hold_full)
          begin
            n.hold      = wb_dat_i[7:0];
            n.hold_full = 1'b1;
            if (q.stat_seen)
            begin
              n.idle_flag = 1'b0;
              n.stat_seen = 1'b0;
            end
          end
        end
        default:
          n.stat_seen = q.stat_seen;
      endcase
    end
    // first half of the clearing sequence
    if (take & ~wb_we_i & (ofs == `UBT_OFS_STATUS))
      n.stat_seen = 1'b1;

    // free-running timer; cost: rate changes wait a tick
    if (~q.uart_en)
    begin
      n.tmr = q.div;
      n.pre = 6'h00;
    end
    else if (tick)
    begin
      n.tmr = q.div;
      n.pre = (q.pre == pre_max) ? 6'h00 : q.pre + 6'h01;
    end
    else
      n.tmr = q.tmr - 8'h01;

    // transmit sequencer
    case (q.fsm)
      UBT_IDLE:
      begin
        n.tx = 1'b1;
        if (active & q.brk)
        begin
          n.brk_frame = 1'b1;
          n.fsm       = UBT_ARM;
        end
        else if (active & q.hold_full)
        begin
          n.shf       = ubt_word(q.hold, q.word9, q.ninth, q.par_en, q.par_odd);
          n.hold_full = 1'b0;
          n.brk_frame = 1'b0;
          n.fsm       = UBT_ARM;
        end
      end
      UBT_ARM:
      begin
        // start waits for the shift clock
        if (bit_en)
        begin
          n.tx   = 1'b0;
          n.bitc = 4'h0;
          n.fsm  = q.brk_frame ? UBT_BRK : UBT_START;
        end
      end
      UBT_START:
      begin
        if (bit_en)
        begin
          n.tx   = q.shf[0];
          n.bitc = 4'h0;
          n.fsm  = UBT_DATA;
        end
      end
      UBT_DATA:
      begin
        if (bit_en)
        begin
          if (q.bitc == last)
          begin
            n.tx   = 1'b1;
            n.bitc = 4'h0;
            n.fsm  = UBT_STOP;
          end
          else
          begin
            n.shf  = {1'b0, q.shf[8:1]};
            n.tx   = q.shf[1];
            n.bitc = q.bitc + 4'h1;
          end
        end
      end
      UBT_BRK:
      begin
        if (bit_en)
        begin
          if (q.bitc == `UBT_BRK_LAST)
          begin
            // a held break repeats whole characters
            n.bitc = 4'h0;
            if (~q.brk)
            begin
              n.tx  = 1'b1;
              n.fsm = UBT_STOP;
            end
          end
          else
            n.bitc = q.bitc + 4'h1;
        end
      end
      UBT_STOP:
      begin
        if (bit_en)
        begin
          if (q.stop2 & (q.bitc == 4'h0))
            n.bitc = 4'h1;
          else
          begin
            n.idle_flag = 1'b1;
            n.bitc      = 4'h0;
            // reload only now, straight into a new start
            if (q.hold_full & ~q.brk)
            begin
              n.shf       = ubt_word(q.hold, q.word9, q.ninth, q.par_en, q.par_odd);
              n.hold_full = 1'b0;
              n.brk_frame = 1'b0;
              n.tx        = 1'b0;
              n.fsm       = UBT_START;
            end
            else
              n.fsm = UBT_IDLE;
          end
        end
      end
      default:
        n.fsm = UBT_IDLE;
    endcase

    // pins; holding data survives tx enable off
    n.oe_n   = ~active;
    n.rx_sel = q.uart_en & q.rx_en; // rx shares format and rate
    if (~active)
    begin
      n.fsm  = UBT_IDLE;
      n.tx   = 1'b1;
      n.bitc = 4'h0;
    end

    // uart off: enables and break clear; format bits and divisor are left alone
    if (~q.uart_en)
    begin
      n.tx_en     = 1'b0;
      n.rx_en     = 1'b0;
      n.brk       = 1'b0;
      n.hold_full = 1'b0;
      n.idle_flag = 1'b1;
      n.fsm       = UBT_IDLE;
    end
  end

  // ***************************************
  // registers
  // ***************************************

  // reset format is 8 bits, no parity, 1 stop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q           <= '0;
      q.div       <= `UBT_RST_DIV;
      q.tmr       <= `UBT_RST_DIV;
      q.idle_flag <= 1'b1;
      q.fsm       <= UBT_IDLE;
      q.tx        <= 1'b1;
      q.oe_n      <= 1'b1;
    end
    else
      q <= n;
  end

  assign wb_dat_o  = q.dat;
  assign wb_ack_o  = q.ack;
  assign tx_o      = q.tx;
  assign tx_oe_n_o = q.oe_n;
  assign rx_sel_o  = q.rx_sel;

  // ***************************************
  // checks
  // ***************************************

  // bit period measure, spoiled by any rate write
  logic [15:0] gap_q;
  logic        chg_q;
  logic        seen_q;
  logic [15:0] exp_gap;

  assign exp_gap = ({8'h00, q.div} + 16'h0001) * (q.hs ? 16'h0010 : 16'h0040);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gap_q  <= 16'h0000;
      chg_q  <= 1'b0;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= bit_en ? 16'h0000 : gap_q + 16'h0001;
      chg_q  <= wr & (ofs != `UBT_OFS_TXDATA) & (ofs != `UBT_OFS_STATUS)
                | (chg_q & ~bit_en) | ~q.uart_en;
      seen_q <= bit_en | seen_q;
    end
  end

  sequence s_bit_edge;
    bit_en & ~chg_q & seen_q;
  endsequence

  sequence s_stop_end;
    (q.fsm == UBT_STOP) & bit_en & ~(q.stop2 & (q.bitc == 4'h0));
  endsequence

  a_bit_period: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bit_edge |-> (gap_q == exp_gap - 16'h0001))
    else $error("bit period does not match divisor");

  a_timer_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick & q.uart_en & ~wr) |=> (q.tmr == $past(q.div)))
    else $error("baud timer did not reload");

  a_idle_line: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == UBT_IDLE) | (q.fsm == UBT_ARM) |-> tx_o)
    else $error("line low outside a frame");

  a_start_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (q.fsm == UBT_START) |-> ~tx_o)
    else $error("start bit not low");

  a_lsb_first: assert property (@(posedge clk_i) disable iff (rst_i)
    ((q.fsm == UBT_START) & bit_en & active) |=> (tx_o == $past(q.shf[0])))
    else $error("first data bit is not the lsb");

  a_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    s_stop_end |=> q.idle_flag ##0 tx_o == (q.fsm != UBT_START))
    else $error("stop end did not set idle");

  a_direct_load: assert property (@(posedge clk_i) disable iff (rst_i)
    ((q.fsm == UBT_IDLE) & active & q.hold_full & ~q.brk) |=> ((q.fsm == UBT_ARM) & ~q.hold_full))
    else $error("idle shifter did not take data");

  a_full_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr & (ofs == `UBT_OFS_TXDATA) & q.hold_full) |=> $stable(q.hold))
    else $error("write into full holding register");

  a_uart_off: assert property (@(posedge clk_i) disable iff (rst_i)
    ~q.uart_en |=> (~q.tx_en & ~q.brk & ~q.hold_full & q.idle_flag))
    else $error("uart off did not reset flags");

  a_tx_release: assert property (@(posedge clk_i) disable iff (rst_i)
    ~active |=> (tx_oe_n_o & (q.fsm == UBT_IDLE)))
    else $error("disabled transmitter still drives");

endmodule
`default_nettype wire

// ===== design/ubt_cfg.svh
// constants for the uart baud, format and transmit block
// Behaviour
// - free-running 8-bit timer sets bit timing
// - rate is clock/64(N+1) or clock/16(N+1)
// - divisor is eight bits, any value 0-255
// - NRZ frame: start, 8/9 bits, 1/2 stop_count_sel
// - parity off, odd or even selectable
// - reset format is 8 bits, no parity, 1 stop
// - words travel least significant bit first
// - both directions share one format and rate
// - all enables set: tx drives, rx listens
// - line held high when no frame is sent
// - uart off releases pins, empties buffers
// - uart off clears enables/break, sets idle/empty
// - uart off aborts; re-enable keeps format and divisor
// - nine-bit words take msb from ninth bit
// - parity replaces the last word bit
// - address mode marks frame by last bit
// - stop count independent of word length
// - shifter reloads only after stop bit
// - sending needs data plus shift clock
// - idle shifter takes holding data at once
// - tx enable off stop_count_sel and releases line
// - status read then write; full blocks writes
// - direct load sets empty; stop sets idle
`ifndef UBT_CFG_SVH
`define UBT_CFG_SVH
// register word offsets, address bits 7:2
`define UBT_OFS_CTRL_FIRST  6'h00
`define UBT_OFS_CTRL_SECOND 6'h01
`define UBT_OFS_BAUD        6'h02
`define UBT_OFS_STATUS      6'h03
`define UBT_OFS_TXDATA      6'h04
// first control register fields
`define UBT_B_UART_EN  7
`define UBT_B_WORD9    6
`define UBT_B_PAR_EN   5
`define UBT_B_PAR_ODD  4
`define UBT_B_STOP2    3
`define UBT_B_BRK      2
`define UBT_B_NINTH    0
// second control register fields
`define UBT_B_TX_EN    7
`define UBT_B_RX_EN    6
`define UBT_B_HS       5
// status register fields
`define UBT_B_TX_EMPTY 0
`define UBT_B_TX_IDLE  1
`define UBT_B_RX_IDLE  2
// reset values and counts
`define UBT_RST_DIV    8'h00
`define UBT_PRE_LOW    6'h3F
`define UBT_PRE_HIGH   6'h0F
`define UBT_BRK_LAST   4'hC
`define UBT_LAST8      4'h7
`define UBT_LAST9      4'h8
`endif

// ===== design/ubt_pkg.sv
// types for the uart baud, format and transmit block
package ubt_pkg;
  // transmitter sequencer, one-hot
  typedef enum logic [5:0] {
    UBT_IDLE  = 6'h01,
    UBT_ARM   = 6'h02,
    UBT_START = 6'h04,
    UBT_DATA  = 6'h08,
    UBT_STOP  = 6'h10,
    UBT_BRK   = 6'h20
  } ubt_fsm_t;

  // whole state of the block
  typedef struct packed {
    logic        uart_en;
    logic        word9;
    logic        par_en;
    logic        par_odd;
    logic        stop2;
    logic        brk;
    logic        ninth;
    logic        tx_en;
    logic        rx_en;
    logic        hs;
    logic [7:0]  div;
    logic [7:0]  tmr;
    logic [5:0]  pre;
    logic [7:0]  hold;
    logic        hold_full;
    logic        idle_flag;
    logic        stat_seen;
    logic        brk_frame;
    ubt_fsm_t    fsm;
    logic [8:0]  shf;
    logic [3:0]  bitc;
    logic        ack;
    logic [31:0] dat;
    logic        tx;
    logic        oe_n;
    logic        rx_sel;
  } ubt_state_t;
endpackage

// ===== tb/ubt_rx_model.sv
// far-end serial receiver model that decodes frames on the transmit line
`timescale 1ns/1ps
`default_nettype none

module ubt_rx_model
(
  // clock and serial line
  input  wire logic        clk_i,
  input  wire logic        line_i,
  input  wire logic        oe_n_i,
  // frame shape set by the bench
  input  wire logic [15:0] bit_clks_i,
  input  wire logic        nine_i,
  input  wire logic        two_i,
  // decoded result
  output logic      [8:0]  word_o,
  output logic             stop_ok_o,
  output int               count_o
);
  int i;

  // sample each bit at its middle, well clear of both edges
  initial
  begin
    count_o = 0;
    word_o = 9'h000;
    stop_ok_o = 1'b1;
    forever
    begin
      @(negedge line_i);
      if (oe_n_i === 1'b0)
      begin
        repeat (bit_clks_i / 2) @(posedge clk_i);
        word_o = 9'h000;
        for (i = 0; i < (nine_i ? 9 : 8); i++)
        begin
          repeat (bit_clks_i) @(posedge clk_i);
          word_o[i] = line_i;
        end
        repeat (bit_clks_i) @(posedge clk_i);
        stop_ok_o = line_i;
        if (two_i)
        begin
          repeat (bit_clks_i) @(posedge clk_i);
          stop_ok_o = stop_ok_o & line_i;
        end
        count_o++;
      end
    end
  end
endmodule

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the uart baud, format and transmit block
`timescale 1ns/1ps
`default_nettype none
`include "ubt_cfg.svh"

module tb_top;
  // design, model and bench signals
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        tx_o;
  logic        tx_oe_n_o;
  logic        rx_sel_o;
  logic [15:0] bit_clks = 16'h0010;
  logic        nine     = 1'b0;
  logic        two      = 1'b0;
  logic [8:0]  mword;
  logic        mstop;
  int          mcount;
  int          err_total   = 0;
  int          check_count = 0;
  int          n = 0;
  int          k;
  logic [31:0] rd;
  logic [7:0]  d;
  logic [8:0]  expq[$];

  always #2.5 clk_i = ~clk_i;

  ubt_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_o(tx_o), .tx_oe_n_o(tx_oe_n_o),
    .rx_sel_o(rx_sel_o));

  ubt_rx_model far (.clk_i(clk_i), .line_i(tx_o), .oe_n_i(tx_oe_n_o), .bit_clks_i(bit_clks),
    .nine_i(nine), .two_i(two), .word_o(mword), .stop_ok_o(mstop), .count_o(mcount));

  // ************************************
  // bus and comparison tasks
  // ************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic we, input logic [5:0] ofs, input logic [7:0] wd);
    int t;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {ofs, 2'b00};
    wb_dat_i <= {24'h0, wd};
    // no local limit: only the watchdog ends a hung wait
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    // ack is registered: one wait state, seen on the second edge
    chk(t, 2);
  endtask

  // software queues a word: status access, then data write
  task automatic send(input logic [7:0] v, input logic [8:0] e);
    wb(1'b0, `UBT_OFS_STATUS, 8'h00);
    wb(1'b1, `UBT_OFS_TXDATA, v);
    expq.push_back(e);
  endtask

  // compare every decoded frame against the expectation queue
  task automatic drain;
    int t;
    for (t = 0; expq.size() > 0 && t < 4000; t++)
    begin
      @(posedge clk_i);
      if (mcount > n)
      begin
        n++;
        chk({23'h0, mword}, {23'h0, expq.pop_front()});
        chk({31'h0, mstop}, 32'h1);
      end
    end
    chk(expq.size(), 32'h0);
    repeat (40) @(posedge clk_i);
  endtask

  // parity, when on, takes the last bit of the word
  function automatic logic [8:0] frame_word(input logic [7:0] v, input logic w9,
    input logic pe, input logic po, input logic n9);
    logic [8:0] w;
    w = {n9 & w9, v};
    if (pe && !w9)
      w[7] = ^v[6:0] ^ po;
    if (pe && w9)
      w[8] = ^v ^ po;
    return w;
  endfunction

  // length of one start bit with a word of 01
  task automatic rate(input logic [7:0] dv, input logic h, input int clks);
    int t;
    bit_clks = 16'(clks);
    wb(1'b1, `UBT_OFS_BAUD, dv);
    wb(1'b1, `UBT_OFS_CTRL_SECOND, {2'b11, h, 5'h00});
    send(8'h01, 9'h001);
    for (t = 0; tx_o !== 1'b0 && t < 3 * clks; t++) @(posedge clk_i);
    for (t = 0; tx_o === 1'b0 && t < 3 * clks; t++) @(posedge clk_i);
    chk(t, clks);
    drain;
  endtask

  task automatic complete_run;
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog well beyond the roughly 7k cycles the tests need
  initial
  begin
    #200000;
    err_total++;
    complete_run();
  end

  // ************************************
  // main sequence
  // ************************************
  initial
  begin
    k = $urandom(32'h9bf14741);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({29'h0, tx_oe_n_o, tx_o, rx_sel_o}, 32'h6);
    wb(1'b0, `UBT_OFS_CTRL_FIRST, 8'h00);
    chk(rd, 32'h0);
    wb(1'b0, `UBT_OFS_STATUS, 8'h00);
    chk(rd, 32'h7);
    wb(1'b0, 6'h3F, 8'h00);
    chk(rd, 32'h0);
    wb(1'b1, `UBT_OFS_CTRL_FIRST, 8'h80);
    wb(1'b1, `UBT_OFS_CTRL_SECOND, 8'hE0);
    repeat (2) @(posedge clk_i);
    chk({30'h0, tx_oe_n_o, rx_sel_o}, 32'h1);
    rate(8'h01, 1'b0, 128);
    rate(8'h03, 1'b1, 64);
    rate(8'h00, 1'b1, 16);
    // every word length, parity and stop combination
    for (k = 0; k < 16; k++)
    begin
      nine = k[3];
      two = k[0];
      d = 8'($urandom);
      wb(1'b1, `UBT_OFS_CTRL_FIRST, {1'b1, k[3:0], 2'b00, k[1]});
      send(d, frame_word(d, k[3], k[2], k[1], k[1]));
      drain;
    end
    // queue behind a busy shifter; a third write is refused
    nine = 1'b0;
    two = 1'b0;
    wb(1'b1, `UBT_OFS_CTRL_FIRST, 8'h80);
    send(8'hA5, 9'h0A5);
    wb(1'b0, `UBT_OFS_STATUS, 8'h00);
    chk(rd, 32'h5);
    send(8'h3C, 9'h03C);
    wb(1'b0, `UBT_OFS_STATUS, 8'h00);
    chk(rd, 32'h4);
    wb(1'b1, `UBT_OFS_TXDATA, 8'hFF);
    drain;
    repeat (200) @(posedge clk_i);
    chk(mcount, n);
    wb(1'b0, `UBT_OFS_STATUS, 8'h00);
    chk(rd, 32'h7);
    // block disabled in mid-frame
    send(8'h00, 9'h000);
    expq.delete();
    repeat (60) @(posedge clk_i);
    wb(1'b1, `UBT_OFS_CTRL_FIRST, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({29'h0, tx_oe_n_o, tx_o, rx_sel_o}, 32'h6);
    wb(1'b0, `UBT_OFS_STATUS, 8'h00);
    chk(rd, 32'h7);
    wb(1'b0, `UBT_OFS_CTRL_SECOND, 8'h00);
    chk(rd, 32'h20);
    wb(1'b0, `UBT_OFS_BAUD, 8'h00);
    chk(rd, 32'h0);
    repeat (300) @(posedge clk_i);
    n = mcount;
    // re-enable keeps the divisor, then transmitter off mid-frame
    wb(1'b1, `UBT_OFS_CTRL_FIRST, 8'h80);
    wb(1'b1, `UBT_OFS_CTRL_SECOND, 8'hA0);
    send(8'hC3, 9'h0C3);
    drain;
    send(8'h00, 9'h000);
    expq.delete();
    repeat (60) @(posedge clk_i);
    wb(1'b1, `UBT_OFS_CTRL_SECOND, 8'h20);
    repeat (2) @(posedge clk_i);
    chk({30'h0, tx_oe_n_o, tx_o}, 32'h3);
    complete_run();
  end
endmodule

`default_nettype wire
